//--- verilog/dsw_cfg.svh
`ifndef DSW_CFG_SVH
`define DSW_CFG_SVH

// ***************************************************************
// Register byte offsets on the plain register port.
// ***************************************************************
`define DSW_ADDR_W 8
`define DSW_OFF_MR0 8'h00
`define DSW_OFF_MR1 8'h04
`define DSW_OFF_STAT 8'h08

// ***************************************************************
// Mode register field positions and reset values.
// ***************************************************************
`define DSW_MR0_DLL_RST 8
`define DSW_MR1_DLL_OFF 0
`define DSW_MR1_RTT0 2
`define DSW_MR1_RTT1 6
`define DSW_MR1_WL_EN 7
`define DSW_MR1_RTT2 9
`define DSW_MR1_QOFF 12
`define DSW_MR_RST 16'h0000

// ***************************************************************
// Status register field positions.
// ***************************************************************
`define DSW_ST_DLL_EN 0
`define DSW_ST_LOCKED 1
`define DSW_ST_WL 2
`define DSW_ST_SR 3
`define DSW_ST_PD 4
`define DSW_ST_CLK_IGN 5
`define DSW_ST_FB_LO 6
`define DSW_ST_FB_UP 7

// ***************************************************************
// Feedback lanes on the data bus.
// ***************************************************************
`define DSW_DQ_W 16
`define DSW_FB_LO_BIT 0
`define DSW_FB_UP_BIT 8

// ***************************************************************
// Timing figures in their own units.
// ***************************************************************
`define DSW_CLK_MHZ 20
`define DSW_T_CKSRE_NS 10
`define DSW_T_WLO_NS 9
`define DSW_DLLK_NCK 512

`endif

//--- verilog/dsw_pkg.sv
`include "dsw_cfg.svh"

package dsw_pkg;

    // Power state of the device as seen by the clock-change logic.
    typedef enum logic [1:0] {
        DSW_IDLE,
        DSW_SELF_REF,
        DSW_PWR_DOWN
    } dsw_pwr_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [15:0] mr0;
        logic [15:0] mr1;
        dsw_pwr_t pwr;
        logic [3:0] sre_cnt;
        logic clk_ign;
        logic [15:0] lock_cnt;
        logic locked;
        logic cke_prev;
        logic strobe_term;
        logic dq_term;
        logic [31:0] rdata;
    } dsw_core_st_t;

    // Whole state of one leveling feedback lane.
    typedef struct packed {
        logic strobe_prev;
        logic smp;
        logic [3:0] cnt;
        logic fb;
    } dsw_wlfb_st_t;

endpackage : dsw_pkg

//--- verilog/dsw_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for a group of pin levels.
module dsw_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    import dsw_pkg::*;

    // Both stages kept as one packed state word.
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dsw_sync_st_t;

    dsw_sync_st_t st_ff; // Current stages.
    dsw_sync_st_t nxt_st; // Next stages.

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
    end

    // Registers clear to zero under reset.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.s2;

endmodule : dsw_sync

//--- verilog/dsw_wlfb.sv
`timescale 1ns/1ps
`include "dsw_cfg.svh"

// One byte lane of write leveling feedback: the strobe rising edge
// samples the clock level and the result is driven after a delay.
module dsw_wlfb #(
    parameter int WLO_NS = `DSW_T_WLO_NS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic en,
    input wire logic strobe,
    input wire logic ck,
    output logic fb
);
    import dsw_pkg::*;

    // Longest output delay rounds down, but never below one cycle.
    localparam int WLO_RAW = (WLO_NS * `DSW_CLK_MHZ) / 1000;
    localparam int WLO_CYC = (WLO_RAW < 1) ? 1 : WLO_RAW;

    dsw_wlfb_st_t st_ff; // Current lane state.
    dsw_wlfb_st_t nxt_st; // Next lane state.
    logic rise; // Strobe rising edge in this cycle.

    assign rise = strobe && !st_ff.strobe_prev;

    // Capture on the edge, then release the sample when the delay ends.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.strobe_prev = strobe;
        if (!en) begin
            // Outside leveling the lane drives low and forgets any sample.
            nxt_st.cnt = 4'h0;
            nxt_st.fb = 1'b0;
        end else if (rise) begin
            // The sampled level is the feedback value itself.
            if (WLO_CYC == 1) begin
                nxt_st.fb = ck;
            end else begin
                nxt_st.smp = ck;
                nxt_st.cnt = 4'(WLO_CYC - 1);
            end
        end else if (st_ff.cnt != 4'h0) begin
            nxt_st.cnt = st_ff.cnt - 4'h1;
            if (st_ff.cnt == 4'h1) begin
                nxt_st.fb = st_ff.smp;
            end
        end
    end

    // State clears under reset.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fb = st_ff.fb;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    property p_fb_idle;
        @(posedge mclk) disable iff (!nrst) !en |=> !fb;
    endproperty
    a_fb_idle: assert property (p_fb_idle)
        else $error("feedback driven outside leveling");

    property p_fb_delay;
        @(posedge mclk) disable iff (!nrst)
            (rise && en) |-> ##WLO_CYC (fb == $past(ck, WLO_CYC) || !$past(en));
    endproperty
    a_fb_delay: assert property (p_fb_delay)
        else $error("feedback late or wrong after strobe edge");

    property p_fb_value;
        @(posedge mclk) disable iff (!nrst)
            $changed(fb) && en |-> fb == $past(ck, WLO_CYC);
    endproperty
    a_fb_value: assert property (p_fb_value)
        else $error("feedback does not match sampled clock");

endmodule : dsw_wlfb

//--- verilog/dsw_core.sv
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "dsw_cfg.svh"


// DLL on/off switching, clock-change tracking and write leveling
// feedback for one DDR3 device, with its mode registers on a plain port.
module dsw_core #(
    parameter int DLLK_CYC = `DSW_DLLK_NCK,
    parameter int CKSRE_NS = `DSW_T_CKSRE_NS,
    parameter int WLO_NS = `DSW_T_WLO_NS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [`DSW_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cke_pin,
    input wire logic refresh_cmd_pin,
    input wire logic odt_pin,
    input wire logic ck_pin,
    input wire logic lower_lane_strobe_pair,
    input wire logic upper_lane_strobe_pair,
    output logic [`DSW_DQ_W-1:0] dq_out,
    output logic dq_oe,
    output logic strobe_term_on,
    output logic dq_term_on,
    output logic dll_enabled,
    output logic dll_locked
);
    import dsw_pkg::*;

    // ***************************************************************
    // Derived timing counts
    // ***************************************************************
    // Least time: round up, never below one cycle.
    localparam int CKSRE_RAW = (CKSRE_NS * `DSW_CLK_MHZ + 999) / 1000;
    localparam int CKSRE_CYC = (CKSRE_RAW < 1) ? 1 : CKSRE_RAW;

    // ***************************************************************
    // Declarations
    // ***************************************************************
    dsw_core_st_t st_ff; // Current state of the whole block.
    dsw_core_st_t nxt_st; // Next state of the whole block.
    logic [5:0] pins_raw; // Pin levels before synchronising.
    logic [5:0] pins_s; // Pin levels after two flip-flops.
    logic cke_s, ref_s, odt_s, ck_s; // Power, termination and clock pins, synchronised.
    logic lo_strobe_s, up_strobe_s; // Lane strobes, synchronised.
    logic wl_active; // Write leveling mode is on.
    logic rtt_en; // Any nominal termination is programmed.
    logic fb_en; // Leveling lanes may sample and drive.
    logic fb_lo, fb_up; // Lower and upper lane feedback bits.
    logic wr_mr0, wr_mr1; // Writes to mode registers 0 and 1.

    // ***************************************************************
    // Helpers
    // ***************************************************************
    // Address match, shared by the write and read decoders.
    function automatic logic f_hit(
        input logic [`DSW_ADDR_W-1:0] addr,
        input logic [`DSW_ADDR_W-1:0] off
    );
        f_hit = (addr == off);
    endfunction : f_hit

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    // All pins come from outside the mclk domain.
    assign pins_raw = {upper_lane_strobe_pair, lower_lane_strobe_pair,
                       ck_pin, odt_pin, refresh_cmd_pin, cke_pin};

    dsw_sync #(
        .W(6)
    ) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign {up_strobe_s, lo_strobe_s, ck_s, odt_s, ref_s, cke_s} = pins_s;

    // ***************************************************************
    // Mode decode
    // ***************************************************************
    assign wl_active = st_ff.mr1[`DSW_MR1_WL_EN];
    assign rtt_en = st_ff.mr1[`DSW_MR1_RTT0] | st_ff.mr1[`DSW_MR1_RTT1]
                  | st_ff.mr1[`DSW_MR1_RTT2];
    // Once the clock is a don't-care the lanes must not sample it.
    assign fb_en = wl_active && !st_ff.clk_ign;
    assign wr_mr0 = reg_wr && f_hit(reg_addr, `DSW_OFF_MR0);
    assign wr_mr1 = reg_wr && f_hit(reg_addr, `DSW_OFF_MR1);

    // ***************************************************************
    // Leveling feedback lanes
    // ***************************************************************
    // Each byte lane has its own sampler so skew is measured per lane.
    dsw_wlfb #(
        .WLO_NS(WLO_NS)
    ) u_fb_lo (
        .mclk(mclk),
        .nrst(nrst),
        .en(fb_en),
        .strobe(lo_strobe_s),
        .ck(ck_s),
        .fb(fb_lo)
    );

    dsw_wlfb #(
        .WLO_NS(WLO_NS)
    ) u_fb_up (
        .mclk(mclk),
        .nrst(nrst),
        .en(fb_en),
        .strobe(up_strobe_s),
        .ck(ck_s),
        .fb(fb_up)
    );

    // ***************************************************************
    // Next-state logic
    // ***************************************************************
    // Register writes, DLL lock tracking, power states and termination.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cke_prev = cke_s;
        nxt_st.rdata = 32'h0;
        // Mode register 0: the DLL reset bit is self-clearing.
        if (wr_mr0) begin
            nxt_st.mr0 = reg_wdata[15:0];
            nxt_st.mr0[`DSW_MR0_DLL_RST] = 1'b0;
        end
        // Mode register 1: holds DLL off, leveling, output disable.
        if (wr_mr1) begin
            nxt_st.mr1 = reg_wdata[15:0];
        end
        // DLL lock: a reset starts relocking, counted on the memory clock.
        if (wr_mr1 && reg_wdata[`DSW_MR1_DLL_OFF]) begin
            // Switching the DLL off drops lock at once.
            nxt_st.locked = 1'b0;
            nxt_st.lock_cnt = 16'h0;
        end else if (wr_mr0 && reg_wdata[`DSW_MR0_DLL_RST]
                     && !st_ff.mr1[`DSW_MR1_DLL_OFF]) begin
            nxt_st.locked = 1'b0;
            nxt_st.lock_cnt = 16'(DLLK_CYC);
        end else if (st_ff.lock_cnt != 16'h0 && !st_ff.clk_ign) begin
            // Relocking pauses while the clock is ignored.
            nxt_st.lock_cnt = st_ff.lock_cnt - 16'h1;
            if (st_ff.lock_cnt == 16'h1) begin
                nxt_st.locked = 1'b1;
            end
        end

        // Power states: entry on a falling clock enable, exit on rising.
        unique case (st_ff.pwr)
            DSW_IDLE: begin
                if (st_ff.cke_prev && !cke_s) begin
                    nxt_st.pwr = ref_s ? DSW_SELF_REF : DSW_PWR_DOWN;
                    nxt_st.sre_cnt = 4'(CKSRE_CYC);
                end
            end
            DSW_SELF_REF: begin
                if (cke_s) begin
                    // Exit: the clock is trusted again.
                    nxt_st.pwr = DSW_IDLE;
                    nxt_st.clk_ign = 1'b0;
                end else if (st_ff.sre_cnt != 4'h0) begin
                    nxt_st.sre_cnt = st_ff.sre_cnt - 4'h1;
                end else begin
                    nxt_st.clk_ign = 1'b1;
                end
            end
            DSW_PWR_DOWN: begin
                // The clock keeps counting here; only the state is kept.
                if (cke_s) begin
                    nxt_st.pwr = DSW_IDLE;
                end else if (st_ff.sre_cnt != 4'h0) begin
                    nxt_st.sre_cnt = st_ff.sre_cnt - 4'h1;
                end
            end
        endcase
        // Termination: in leveling ODT switches the strobes only.
        if (st_ff.pwr == DSW_SELF_REF) begin
            // Termination is unavailable in self-refresh.
            nxt_st.strobe_term = 1'b0;
            nxt_st.dq_term = 1'b0;
        end else if (wl_active) begin
            nxt_st.strobe_term = odt_s;
            nxt_st.dq_term = 1'b0;
        end else begin
            nxt_st.strobe_term = odt_s && rtt_en;
            nxt_st.dq_term = odt_s && rtt_en;
        end

        // Register read: data stand one cycle after the strobe only.
        if (reg_rd) begin // Unmapped addresses read as zero.
            if (f_hit(reg_addr, `DSW_OFF_MR0)) begin
                nxt_st.rdata = {16'h0, st_ff.mr0};
            end else if (f_hit(reg_addr, `DSW_OFF_MR1)) begin
                nxt_st.rdata = {16'h0, st_ff.mr1};
            end else if (f_hit(reg_addr, `DSW_OFF_STAT)) begin
                nxt_st.rdata[`DSW_ST_DLL_EN] = !st_ff.mr1[`DSW_MR1_DLL_OFF];
                nxt_st.rdata[`DSW_ST_LOCKED] = st_ff.locked;
                nxt_st.rdata[`DSW_ST_WL] = wl_active;
                nxt_st.rdata[`DSW_ST_SR] = (st_ff.pwr == DSW_SELF_REF);
                nxt_st.rdata[`DSW_ST_PD] = (st_ff.pwr == DSW_PWR_DOWN);
                nxt_st.rdata[`DSW_ST_CLK_IGN] = st_ff.clk_ign;
                nxt_st.rdata[`DSW_ST_FB_LO] = fb_lo;
                nxt_st.rdata[`DSW_ST_FB_UP] = fb_up;
            end
        end
    end

    // ***************************************************************
    // State register
    // ***************************************************************
    // Reset leaves the DLL enabled but unlocked, leveling off.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.mr0 <= `DSW_MR_RST;
            st_ff.mr1 <= `DSW_MR_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    // Prime bits carry feedback, the rest are held low.
    always_comb begin
        dq_out = '0;
        dq_out[`DSW_FB_LO_BIT] = fb_lo;
        dq_out[`DSW_FB_UP_BIT] = fb_up;
    end

    // Output disable keeps the data pins released during leveling.
    assign dq_oe = wl_active && !st_ff.mr1[`DSW_MR1_QOFF];
    assign strobe_term_on = st_ff.strobe_term;
    assign dq_term_on = st_ff.dq_term;
    assign dll_enabled = !st_ff.mr1[`DSW_MR1_DLL_OFF];
    assign dll_locked = st_ff.locked;
    assign reg_rdata = st_ff.rdata;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    property p_dll_off;
        @(posedge mclk) disable iff (!nrst)
            wr_mr1 && reg_wdata[`DSW_MR1_DLL_OFF]
            |=> !dll_enabled && !dll_locked;
    endproperty
    a_dll_off: assert property (p_dll_off)
        else $error("DLL still on after disabling write");

    property p_dll_stays_off;
        @(posedge mclk) disable iff (!nrst)
            !dll_enabled && !wr_mr1 |=> !dll_enabled && !dll_locked;
    endproperty
    a_dll_stays_off: assert property (p_dll_stays_off)
        else $error("DLL came back without a register write");

    property p_clk_ign;
        @(posedge mclk) disable iff (!nrst)
            st_ff.pwr == DSW_SELF_REF && st_ff.sre_cnt == 4'h0 && !cke_s
            |=> st_ff.clk_ign;
    endproperty
    a_clk_ign: assert property (p_clk_ign)
        else $error("clock not ignored after entry delay");

    property p_ign_only_sr;
        @(posedge mclk) disable iff (!nrst)
            st_ff.clk_ign |-> st_ff.pwr == DSW_SELF_REF && !fb_en;
    endproperty
    a_ign_only_sr: assert property (p_ign_only_sr)
        else $error("clock ignored outside self-refresh");

    property p_wl_mode;
        @(posedge mclk) disable iff (!nrst)
            wr_mr1 |=> wl_active == $past(reg_wdata[`DSW_MR1_WL_EN]);
    endproperty
    a_wl_mode: assert property (p_wl_mode)
        else $error("leveling mode does not follow register bit");

    property p_wl_term;
        @(posedge mclk) disable iff (!nrst)
            wl_active && st_ff.pwr != DSW_SELF_REF
            |=> !dq_term_on && strobe_term_on == $past(odt_s);
    endproperty
    a_wl_term: assert property (p_wl_term)
        else $error("leveling termination wrong");

    property p_lanes;
        @(posedge mclk) disable iff (!nrst)
            dq_oe |-> dq_out[`DSW_FB_LO_BIT] == fb_lo
                      && dq_out[`DSW_FB_UP_BIT] == fb_up
                      && $countones(dq_out) <= 2;
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("lane feedback on wrong data bit");

    c_sr_ignore: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(st_ff.clk_ign));
    c_relock: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(dll_locked));
    c_wl_rise: cover property (@(posedge mclk) disable iff (!nrst)
        wl_active && $rose(fb_lo));

endmodule : dsw_core

//--- testbench/dsw_ctrl_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Controller side: power pins, clock level and the two lane strobes.
// ****************************************************************
module dsw_ctrl_model (
    input wire logic mclk,
    output logic cke_pin,
    output logic refresh_cmd_pin,
    output logic odt_pin,
    output logic ck_pin,
    output logic [1:0] strobe
);
    // Idle pins: clock enabled, termination off, strobes parked low.
    initial begin
        cke_pin = 1'b1;
        refresh_cmd_pin = 1'b0;
        odt_pin = 1'b0;
        ck_pin = 1'b0;
        strobe = 2'b00;
    end

    // Power change with ODT held low, so the pins never move mid-change.
    task automatic power(input logic cke_v, input logic ref_v);
        @(posedge mclk);
        odt_pin <= 1'b0;
        refresh_cmd_pin <= ref_v;
        cke_pin <= cke_v;
    endtask : power

    // Termination pin level.
    task automatic term(input logic v);
        @(posedge mclk);
        odt_pin <= v;
    endtask : term

    // One strobe pulse; the clock level settles first and stays until the next.
    task automatic pulse(input int lane, input logic lvl);
        @(posedge mclk);
        ck_pin <= lvl;
        @(posedge mclk);
        strobe[lane] <= 1'b1;
        repeat (2) @(posedge mclk);
        strobe[lane] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : pulse
endmodule : dsw_ctrl_model

//--- testbench/dsw_core_bench.sv
`timescale 1ns/1ps
`include "dsw_cfg.svh"

module dsw_core_bench;
    localparam int DLLK = 8; // Short lock count keeps the run brief.
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rdv, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic cke, rfc, odt, ck, dq_oe, st_on, dq_on, dll_en, dll_lk;
    logic [1:0] stb;
    logic [15:0] dq_out, exp_dq;
    int num_errors = 0, checks = 0;

    // 20 MHz clock.
    always #25 mclk = ~mclk;

    dsw_ctrl_model i_ctl (.mclk(mclk), .cke_pin(cke), .refresh_cmd_pin(rfc),
        .odt_pin(odt), .ck_pin(ck), .strobe(stb));

    dsw_core #(.DLLK_CYC(DLLK)) i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cke_pin(cke), .refresh_cmd_pin(rfc), .odt_pin(odt), .ck_pin(ck),
        .lower_lane_strobe_pair(stb[0]), .upper_lane_strobe_pair(stb[1]),
        .dq_out(dq_out), .dq_oe(dq_oe), .strobe_term_on(st_on), .dq_term_on(dq_on),
        .dll_enabled(dll_en), .dll_locked(dll_lk));

    // ****************************************************************
    // Checking and bus tasks.
    // ****************************************************************
    function automatic logic [31:0] st_exp(input logic en, lk, wl, sr, ign);
        return {24'h0, 2'b00, ign, 1'b0, sr, wl, lk, en};
    endfunction : st_exp

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rdv = reg_rdata;
    endtask : rd

    task automatic end_of_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // A hang costs one mismatch; the sequence needs far less time.
    initial begin
        #2000000;
        num_errors++;
        end_of_test();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        int lane;
        logic lvl;
        lane = $urandom(32'h9ddf);
        exp_dq = 16'h0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        chk({dll_en, dll_lk, dq_oe}, 3'b100);
        rd(`DSW_OFF_STAT);
        chk(rdv, st_exp(1, 0, 0, 0, 0));
        rd(8'h0c);
        chk(rdv, 32'h0);
        // Lock count from a reset request, then the reset bit reads back clear.
        wr(`DSW_OFF_MR0, 32'h100);
        repeat (DLLK - 2) @(posedge mclk);
        @(negedge mclk);
        chk(dll_lk, 1'b0);
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk(dll_lk, 1'b1);
        rd(`DSW_OFF_MR0);
        chk(rdv, 32'h0);
        // DLL off from idle, then self-refresh: clock ignored, then exit.
        wr(`DSW_OFF_MR1, 32'h1);
        chk({dll_en, dll_lk}, 2'b00);
        i_ctl.power(1'b0, 1'b1);
        repeat (8) @(posedge mclk);
        rd(`DSW_OFF_STAT);
        chk(rdv, st_exp(0, 0, 0, 1, 1));
        i_ctl.power(1'b1, 1'b0);
        repeat (4) @(posedge mclk);
        rd(`DSW_OFF_STAT);
        chk(rdv, st_exp(0, 0, 0, 0, 0));
        // DLL back on, then a reset request and a full relock.
        wr(`DSW_OFF_MR1, 32'h0);
        chk({dll_en, dll_lk}, 2'b10);
        wr(`DSW_OFF_MR0, 32'h100);
        repeat (DLLK) @(posedge mclk);
        @(negedge mclk);
        chk(dll_lk, 1'b1);
        // Precharge power-down, exit, then a DLL reset at the new clock.
        i_ctl.power(1'b0, 1'b0);
        repeat (8) @(posedge mclk);
        rd(`DSW_OFF_STAT);
        chk(rdv & 32'h18, 32'h10);
        i_ctl.power(1'b1, 1'b0);
        repeat (8) @(posedge mclk);
        wr(`DSW_OFF_MR0, 32'h100);
        repeat (8) @(posedge mclk);
        rd(`DSW_OFF_STAT);
        chk(rdv, st_exp(1, 1, 0, 0, 0));
        // Termination in normal mode, then in leveling mode.
        wr(`DSW_OFF_MR1, 32'h4);
        i_ctl.term(1'b1);
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk({st_on, dq_on}, 2'b11);
        wr(`DSW_OFF_MR1, 32'h84);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({st_on, dq_on, dq_oe}, 3'b101);
        rd(`DSW_OFF_STAT);
        chk(rdv, st_exp(1, 1, 1, 0, 0));
        i_ctl.term(1'b0);
        // Fixed rising pair per lane, then random lanes and levels.
        for (int i = 0; i < 28; i++) begin
            lane = (i < 4) ? i / 2 : $urandom % 2;
            lvl = (i < 4) ? i[0] : 1'($urandom);
            i_ctl.pulse(lane, lvl);
            exp_dq[lane * 8] = lvl;
            @(negedge mclk);
            chk(dq_out, exp_dq);
        end
        wr(`DSW_OFF_MR1, 32'h1084);
        chk(dq_oe, 1'b0);
        wr(`DSW_OFF_MR1, 32'h0);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({dq_out, dq_oe, st_on}, 18'h0);
        // Second reset in mid-run.
        wr(`DSW_OFF_MR1, 32'h1);
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rd(`DSW_OFF_MR1);
        chk(rdv, 32'h0);
        chk(dll_en, 1'b1);
        end_of_test();
    end
endmodule : dsw_core_bench
